// >>> src/psg_pkg.sv
`default_nettype none
package psg_pkg;
  localparam logic [7:0] PinStatusLowOffset  = 8'h1c;
  localparam logic [7:0] PinStatusHighOffset = 8'h1d;
  localparam logic [7:0] PortSelectOffset    = 8'h1e;
  localparam logic [7:0] PinStatusLowReset   = 8'h00;
  localparam logic [7:0] PinStatusHighReset  = 8'h00;
  localparam logic [7:0] PortSelectReset     = 8'h01;
  localparam int         SelLinkABit         = 0;
  localparam int         SelLinkBBit         = 1;
  localparam int         SecondAddrEnBit     = 2;
  localparam int         PinCount            = 9;
  localparam logic [6:0] OwnAddrReset        = 7'h00;
  typedef enum logic [1:0] {
    RouteNone,
    RouteLinkA,
    RouteLinkB
  } psg_route_t;
endpackage
`default_nettype wire

// >>> src/psg_pin_sampler.sv
`default_nettype none
module psg_pin_sampler (
  input  wire logic                           ref_clk,
  input  wire logic                           rst,
  input  wire logic [psg_pkg::PinCount-1:0]   pinLevel,
  output logic      [psg_pkg::PinCount-1:0]   pinSample
);
  logic [psg_pkg::PinCount-1:0] sample_q;
  logic [psg_pkg::PinCount-1:0] sample_d;

  genvar i;
  generate
    for (i = 0; i < psg_pkg::PinCount; i++) begin : g_pin
      assign sample_d[i] = pinLevel[i];
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sample_q <= '0;
    end else begin
      sample_q <= sample_d;
    end
  end

  assign pinSample = sample_q;
endmodule
`default_nettype wire

// >>> src/psg_port_select.sv
`default_nettype none
module psg_port_select (
  input  wire logic                           ref_clk,
  input  wire logic                           rst,
  input  wire logic [psg_pkg::PinCount-1:0]   pinLevel,
  input  wire logic [6:0]                     ownBusAddress,
  input  wire logic                           duplicateMode,
  input  wire logic                           regWrite,
  input  wire logic                           regRead,
  input  wire logic [7:0]                     regAddr,
  input  wire logic [7:0]                     regWdata,
  input  wire logic [6:0]                     targetAddr,
  output logic      [7:0]                     regRdata,
  output logic                                addrMatch,
  output logic                                viaSecondAddr,
  output logic                                writeLinkA,
  output logic                                writeLinkB,
  output logic                                writeShared,
  output logic                                readLinkB,
  output logic                                remoteLinkBEnable
);

  logic [psg_pkg::PinCount-1:0] pinSample;
  logic                         selLinkA_q;
  logic                         selLinkA_d;
  logic                         selLinkB_q;
  logic                         selLinkB_d;
  logic                         secondEn_q;
  logic                         secondEn_d;
  logic [7:0]                   rdata_q;
  logic [7:0]                   rdata_d;
  logic                         addrMatch_q;
  logic                         addrMatch_d;
  logic                         viaSecond_q;
  logic                         viaSecond_d;
  logic                         writeLinkA_q;
  logic                         writeLinkA_d;
  logic                         writeLinkB_q;
  logic                         writeLinkB_d;
  logic                         writeShared_q;
  logic                         writeShared_d;
  logic                         readLinkB_q;
  logic                         readLinkB_d;
  logic                         remoteB_q;
  logic                         remoteB_d;
  logic [7:0]                   lowStatus;
  logic [7:0]                   highStatus;
  logic [7:0]                   selStatus;
  logic [6:0]                   secondAddr;
  logic                         isPrimary;
  logic                         isSecond;
  logic                         isMatch;
  logic                         selWrite;
  psg_pkg::psg_route_t          primaryRoute;
  psg_pkg::psg_route_t          accessRoute;

  // Pin sampling stage
  psg_pin_sampler u_sampler (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .pinLevel  (pinLevel),
    .pinSample (pinSample)
  );

  // Status views of sampled pins and of the port select register
  always_comb begin
    lowStatus  = {pinSample[7:5], 1'b0, pinSample[3:0]};
    highStatus = {7'h00, pinSample[8]};
    selStatus  = {5'h00, secondEn_q, selLinkB_q, selLinkA_q};
  end

  // Target address decode
  always_comb begin
    secondAddr = 7'(ownBusAddress + 7'h01);
    isPrimary  = (targetAddr == ownBusAddress);
    isSecond   = secondEn_q && (targetAddr == secondAddr);
    isMatch    = isPrimary || isSecond;
    selWrite   = regWrite && isMatch && (regAddr == psg_pkg::PortSelectOffset);
  end

  // Port select register
  always_comb begin
    selLinkA_d = selLinkA_q;
    selLinkB_d = selLinkB_q;
    secondEn_d = secondEn_q;
    if (selWrite) begin
      selLinkA_d = regWdata[psg_pkg::SelLinkABit];
      selLinkB_d = regWdata[psg_pkg::SelLinkBBit];
      secondEn_d = regWdata[psg_pkg::SecondAddrEnBit];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      selLinkA_q <= psg_pkg::PortSelectReset[psg_pkg::SelLinkABit];
      selLinkB_q <= psg_pkg::PortSelectReset[psg_pkg::SelLinkBBit];
      secondEn_q <= psg_pkg::PortSelectReset[psg_pkg::SecondAddrEnBit];
    end else begin
      selLinkA_q <= selLinkA_d;
      selLinkB_q <= selLinkB_d;
      secondEn_q <= secondEn_d;
    end
  end

  // Read data register
  always_comb begin
    rdata_d = rdata_q;
    if (regRead && isMatch) begin
      unique case (regAddr)
        psg_pkg::PinStatusLowOffset:  rdata_d = lowStatus;
        psg_pkg::PinStatusHighOffset: rdata_d = highStatus;
        psg_pkg::PortSelectOffset:    rdata_d = selStatus;
        default:                      rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_q <= psg_pkg::PinStatusLowReset;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Routing of the current access
  always_comb begin
    primaryRoute = psg_pkg::RouteNone;
    if (secondEn_q) begin
      primaryRoute = psg_pkg::RouteLinkA;
    end else if (selLinkB_q) begin
      primaryRoute = psg_pkg::RouteLinkB;
    end else if (selLinkA_q) begin
      primaryRoute = psg_pkg::RouteLinkA;
    end
    accessRoute = psg_pkg::RouteNone;
    if (isSecond) begin
      accessRoute = psg_pkg::RouteLinkB;
    end else if (isPrimary) begin
      accessRoute = primaryRoute;
    end
  end

  // Address match flags
  always_comb begin
    addrMatch_d = isMatch;
    viaSecond_d = isSecond;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      addrMatch_q <= 1'b0;
      viaSecond_q <= 1'b0;
    end else begin
      addrMatch_q <= addrMatch_d;
      viaSecond_q <= viaSecond_d;
    end
  end

  // Steering pulses
  always_comb begin
    writeLinkA_d  = 1'b0;
    writeLinkB_d  = 1'b0;
    writeShared_d = 1'b0;
    readLinkB_d   = 1'b0;
    if (regWrite) begin
      writeShared_d = (accessRoute != psg_pkg::RouteNone);
      writeLinkA_d  = (accessRoute == psg_pkg::RouteLinkA) ||
                      (isPrimary && !secondEn_q && selLinkA_q);
      writeLinkB_d  = (accessRoute == psg_pkg::RouteLinkB);
    end
    if (regRead) begin
      readLinkB_d = (accessRoute == psg_pkg::RouteLinkB);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      writeLinkA_q  <= 1'b0;
      writeLinkB_q  <= 1'b0;
      writeShared_q <= 1'b0;
      readLinkB_q   <= 1'b0;
    end else begin
      writeLinkA_q  <= writeLinkA_d;
      writeLinkB_q  <= writeLinkB_d;
      writeShared_q <= writeShared_d;
      readLinkB_q   <= readLinkB_d;
    end
  end

  // Remote forwarding over link B
  always_comb begin
    remoteB_d = !duplicateMode || secondEn_q;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      remoteB_q <= 1'b0;
    end else begin
      remoteB_q <= remoteB_d;
    end
  end

  assign regRdata          = rdata_q;
  assign addrMatch         = addrMatch_q;
  assign viaSecondAddr     = viaSecond_q;
  assign writeLinkA        = writeLinkA_q;
  assign writeLinkB        = writeLinkB_q;
  assign writeShared       = writeShared_q;
  assign readLinkB         = readLinkB_q;
  assign remoteLinkBEnable = remoteB_q;
endmodule
`default_nettype wire

// >>> tb/psg_host_model.sv
`default_nettype none
module psg_host_model (
  input  wire logic       ref_clk,
  output logic            regWrite,
  output logic            regRead,
  output logic      [7:0] regAddr,
  output logic      [7:0] regWdata,
  output logic      [6:0] targetAddr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {regWrite, regRead, regAddr, regWdata, targetAddr} = '0;
  task automatic acc(input logic w, input logic [7:0] a, d, input logic [6:0] t);
    @(posedge ref_clk) #1;
    {regWrite, regRead, regAddr, regWdata, targetAddr} = {w, !w, a, d, t};
    @(posedge ref_clk) #1;
    {regWrite, regRead, regAddr, regWdata, targetAddr} = {2'b00, ~a, ~d, ~t};
  endtask
endmodule
`default_nettype wire

// >>> tb/psg_port_select_checker.sv
`default_nettype none
module psg_port_select_checker (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [6:0] targetAddr,
  input wire logic [6:0] ownBusAddress,
  input wire logic       addrMatch,
  input wire logic       viaSecondAddr,
  input wire logic       writeLinkA,
  input wire logic       writeLinkB,
  input wire logic       writeShared,
  input wire logic       readLinkB
);
  wire logic [6:0] nextAddr = ownBusAddress + 7'h01;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_PRIM: assert property (targetAddr == ownBusAddress |=> addrMatch)
    else $error("primary missed");
  AST_MISS: assert property (targetAddr != ownBusAddress && targetAddr != nextAddr |=> !addrMatch)
    else $error("stray match");
  AST_SHR: assert property (writeLinkA || writeLinkB |-> writeShared)
    else $error("shared not written");
  AST_WSRC: assert property (writeShared |-> addrMatch && $past(regWrite))
    else $error("write without request");
  AST_RSRC: assert property (readLinkB |-> addrMatch && $past(regRead))
    else $error("read without request");
  AST_SECW: assert property (viaSecondAddr && writeShared |-> writeLinkB)
    else $error("second addr missed B");
  AST_SECM: assert property (viaSecondAddr |-> addrMatch)
    else $error("second hit unmatched");
  AST_NOA: assert property (writeLinkA |-> !viaSecondAddr)
    else $error("second addr wrote A");
  cover property (writeLinkA && writeLinkB);
  cover property (viaSecondAddr && writeShared);
  cover property (readLinkB);
endmodule
bind psg_port_select psg_port_select_checker chk_i (.*);
`default_nettype wire

// >>> tb/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] Own = 7'h2c;
  logic       ref_clk = 0, rst = 1, duplicateMode = 0;
  logic [8:0] pinLevel = 9'h15a;
  logic [6:0] ownBusAddress = Own, targetAddr;
  logic [7:0] regAddr, regWdata, regRdata;
  logic       regWrite, regRead, addrMatch, viaSecondAddr, readLinkB, remoteLinkBEnable;
  logic       writeLinkA, writeLinkB, writeShared;
  int         errors = 0, checks_done = 0;
  psg_port_select uut (
    .ref_clk           (ref_clk),
    .rst               (rst),
    .pinLevel          (pinLevel),
    .ownBusAddress     (ownBusAddress),
    .duplicateMode     (duplicateMode),
    .regWrite          (regWrite),
    .regRead           (regRead),
    .regAddr           (regAddr),
    .regWdata          (regWdata),
    .targetAddr        (targetAddr),
    .regRdata          (regRdata),
    .addrMatch         (addrMatch),
    .viaSecondAddr     (viaSecondAddr),
    .writeLinkA        (writeLinkA),
    .writeLinkB        (writeLinkB),
    .writeShared       (writeShared),
    .readLinkB         (readLinkB),
    .remoteLinkBEnable (remoteLinkBEnable)
  );
  psg_host_model host (
    .ref_clk    (ref_clk),
    .regWrite   (regWrite),
    .regRead    (regRead),
    .regAddr    (regAddr),
    .regWdata   (regWdata),
    .targetAddr (targetAddr)
  );
  function automatic logic [7:0] steer();
    return {4'h0, writeLinkA, writeLinkB, writeShared, readLinkB};
  endfunction
  task automatic chk(input logic [7:0] g, e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, d, input logic [6:0] t = Own);
    host.acc(1, a, d, t);
  endtask
  task automatic rd(input logic [7:0] a, e);
    host.acc(0, a, 8'h00, Own);
    chk(regRdata, e);
  endtask
  task automatic t_status;
    rd(8'h1e, 8'h01);
    rd(8'h1c, 8'h4a);
    rd(8'h1d, 8'h01);
    pinLevel = 9'h0a5;
    wr(8'h1c, 8'hff);
    rd(8'h1c, 8'ha5);
    rd(8'h1d, 8'h00);
  endtask
  task automatic t_select;
    wr(8'h1e, 8'hff);
    rd(8'h1e, 8'h07);
    wr(8'h40, 8'h00);
    chk(steer(), 8'h0a);
    wr(8'h40, 8'h00, Own + 7'h01);
    chk(steer(), 8'h06);
    chk({7'h0, viaSecondAddr}, 8'h01);
    wr(8'h1e, 8'h03);
    wr(8'h40, 8'h00, Own + 7'h01);
    chk({7'h0, addrMatch}, 8'h00);
    wr(8'h40, 8'h00);
    chk(steer(), 8'h0e);
    rd(8'h40, 8'h00);
    chk(steer(), 8'h01);
    wr(8'h1e, 8'h02);
    wr(8'h40, 8'h00);
    chk(steer(), 8'h06);
    wr(8'h1e, 8'h01);
    rd(8'h40, 8'h00);
    chk(steer(), 8'h00);
  endtask
  task automatic t_remote;
    duplicateMode = 1;
    wr(8'h1e, 8'h04);
    repeat (2) @(posedge ref_clk);
    #1 chk({7'h0, remoteLinkBEnable}, 8'h01);
    wr(8'h1e, 8'h00);
    repeat (2) @(posedge ref_clk);
    #1 chk({7'h0, remoteLinkBEnable}, 8'h00);
  endtask
  task automatic tally_and_finish;
    if (errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial forever #4 ref_clk = ~ref_clk;
  initial begin
    repeat (4) @(posedge ref_clk);
    #1 rst = 0;
    t_status;
    t_select;
    t_remote;
    tally_and_finish;
  end
  initial begin
    #5us;
    errors++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
